// ### core/smbus_client.sv
// Purpose: client end of the two-wire bus, reaching a 256-entry register space
// Assumes: bus lines arrive asynchronously and are filtered by three flops
// Notes: the register space itself sits outside, on the user-side ports
//
// What this block does
// - start is data falling while clock high
// - first byte: seven address bits, then direction
// - direction 0 writes, 1 reads
// - answer only address 0101000
// - bytes are eight bits, msb first
// - client acknowledges its own address byte and every written byte
// - host leaves last read byte unacknowledged
// - reads continue while acknowledged, stop otherwise
// - stop is data rising while clock high
// - stop returns the client to idle
// - client never holds the clock low
// - accepts system-management and plain framing alike
// - enabled: clock low 30 ms resets interface
// - enabled: both lines high 200 us reset
// - pointer steps per data byte, wraps
// - first written byte loads the pointer
`timescale 1ns/100ps
`default_nettype none
module smbus_client #(
   parameter int TIMEOUT_CYCLES = smbus_pkg::TIMEOUT_CYCLES,
   parameter int IDLE_CYCLES = smbus_pkg::IDLE_CYCLES
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // bus side; the client has no clock driver at all
   smbus_if.client bus,
   // control
   input wire logic timeout_enable,
   // register space access
   input wire logic [7:0] rd_data,
   output logic [7:0] reg_ptr,
   output logic wr_valid,
   output logic [7:0] wr_addr,
   output logic [7:0] wr_data,
   output logic busy
);
   ////////////////////////////////////////////////////////////////////////////
   // types and declarations
   typedef enum logic [2:0] {
      S_IDLE, S_ADDR, S_ADDR_ACK, S_RX, S_RX_ACK, S_TX, S_TX_ACK, S_IGNORE
   } state_type;
   localparam int CNT_W = 20;
   state_type state, next_state;     // serial interface state
   logic [2:0] clk_sync, next_clk_sync; // clock line synchroniser
   logic [2:0] dat_sync, next_dat_sync; // data line synchroniser
   logic clk_f, next_clk_f;          // filtered clock level
   logic dat_f, next_dat_f;          // filtered data level
   logic clk_p, next_clk_p;          // filtered clock, one cycle back
   logic dat_p, next_dat_p;          // filtered data, one cycle back
   logic [7:0] shift, next_shift;    // byte shifter
   logic [3:0] bit_cnt, next_bit_cnt; // bits moved in this byte
   logic dir, next_dir;              // latched direction
   logic first, next_first;          // next written byte is the pointer
   logic nack, next_nack;            // host answer in read ack slot
   logic oe, next_oe;                // data line pull-down
   logic [7:0] next_reg_ptr;
   logic next_wr_valid;
   logic [7:0] next_wr_addr;
   logic [7:0] next_wr_data;
   logic next_busy;
   logic [CNT_W-1:0] low_cnt, next_low_cnt;   // clock-low time
   logic [CNT_W-1:0] high_cnt, next_high_cnt; // both-high time
   logic clk_rise, clk_fall, start_det, stop_det, low_tmo, idle_tmo;

   ////////////////////////////////////////////////////////////////////////////
   // bus event decode from the filtered levels
   always_comb begin
      clk_rise = clk_f && !clk_p;
      clk_fall = !clk_f && clk_p;
      start_det = clk_f && clk_p && dat_p && !dat_f;
      stop_det = clk_f && clk_p && !dat_p && dat_f;
      low_tmo = timeout_enable && (low_cnt == CNT_W'(TIMEOUT_CYCLES));
      idle_tmo = timeout_enable && (high_cnt == CNT_W'(IDLE_CYCLES));
   end

   ////////////////////////////////////////////////////////////////////////////
   // next-state logic
   always_comb begin
      // synchronisers: a level counts once stages two and three agree
      next_clk_sync = {clk_sync[1:0], bus.bus_clock_line};
      next_dat_sync = {dat_sync[1:0], bus.bus_data_line};
      next_clk_f = (clk_sync[1] == clk_sync[2]) ? clk_sync[2] : clk_f;
      next_dat_f = (dat_sync[1] == dat_sync[2]) ? dat_sync[2] : dat_f;
      next_clk_p = clk_f;
      next_dat_p = dat_f;
      // hold by default; the write strobe defaults low
      next_state = state;
      next_shift = shift;
      next_bit_cnt = bit_cnt;
      next_dir = dir;
      next_first = first;
      next_nack = nack;
      next_oe = oe;
      next_reg_ptr = reg_ptr;
      next_wr_valid = 1'h0;
      next_wr_addr = wr_addr;
      next_wr_data = wr_data;
      // timeout counters: clear on activity, count up, saturate at their limit
      next_low_cnt = clk_f ? '0 : low_cnt + CNT_W'(low_cnt != CNT_W'(TIMEOUT_CYCLES));
      next_high_cnt = !(clk_f && dat_f) ? '0 : high_cnt + CNT_W'(high_cnt != CNT_W'(IDLE_CYCLES));
      // both framings share one engine: no byte-count byte is expected
      if (stop_det || start_det || low_tmo || idle_tmo) begin
         // release the line; stop or timeout idles, a start keeps the pointer
         next_state = start_det ? S_ADDR : S_IDLE;
         next_oe = 1'h0;
         next_bit_cnt = '0;
      end else begin
         case (state)
            S_ADDR: begin
               // shift address and direction in, msb first
               if (clk_rise) begin
                  next_shift = {shift[6:0], dat_f};
                  next_bit_cnt = bit_cnt + 4'h1;
               end else if (clk_fall && bit_cnt == smbus_pkg::BYTE_BITS) begin
                  if (shift[7:1] == smbus_pkg::CLIENT_ADDR) begin
                     next_dir = shift[0];
                     next_oe = 1'h1;
                     next_state = S_ADDR_ACK;
                  end else begin
                     // not ours: stay released until next start
                     next_state = S_IGNORE;
                  end
               end
            end
            S_ADDR_ACK: begin
               // end of ack slot: branch on direction
               if (clk_fall) begin
                  if (dir == smbus_pkg::DIR_READ) begin
                     next_shift = rd_data;
                     next_oe = !rd_data[7];
                     next_bit_cnt = 4'h1;
                     next_state = S_TX;
                  end else begin
                     next_first = 1'h1;
                     next_oe = 1'h0;
                     next_bit_cnt = '0;
                     next_state = S_RX;
                  end
               end
            end
            S_RX: begin
               // receive a byte, msb first
               if (clk_rise) begin
                  next_shift = {shift[6:0], dat_f};
                  next_bit_cnt = bit_cnt + 4'h1;
               end else if (clk_fall && bit_cnt == smbus_pkg::BYTE_BITS) begin
                  next_oe = 1'h1;
                  next_state = S_RX_ACK;
                  if (first) begin
                     // pointer byte only sets the pointer
                     next_reg_ptr = shift;
                     next_first = 1'h0;
                  end else begin
                     next_wr_valid = 1'h1;
                     next_wr_addr = reg_ptr;
                     next_wr_data = shift;
                     next_reg_ptr = reg_ptr + 8'h01;
                  end
               end
            end
            S_RX_ACK: begin
               // release after ack slot
               if (clk_fall) begin
                  next_oe = 1'h0;
                  next_bit_cnt = '0;
                  next_state = S_RX;
               end
            end
            S_TX: begin
               // drive next bit on each clock fall
               if (clk_fall) begin
                  if (bit_cnt == smbus_pkg::BYTE_BITS) begin
                     next_oe = 1'h0;
                     next_reg_ptr = reg_ptr + 8'h01;
                     next_state = S_TX_ACK;
                  end else begin
                     next_shift = {shift[6:0], 1'h0};
                     next_oe = !shift[6];
                     next_bit_cnt = bit_cnt + 4'h1;
                  end
               end
            end
            S_TX_ACK: begin
               // sample host answer, then continue or stop driving
               if (clk_rise) begin
                  next_nack = dat_f;
               end else if (clk_fall) begin
                  if (nack) begin
                     next_state = S_IGNORE;
                  end else begin
                     next_shift = rd_data;
                     next_oe = !rd_data[7];
                     next_bit_cnt = 4'h1;
                     next_state = S_TX;
                  end
               end
            end
            S_IDLE, S_IGNORE: begin
               // wait for a start
               next_oe = 1'h0;
            end
            default: begin
               next_state = S_IDLE;
               next_oe = 1'h0;
            end
         endcase
      end
      next_busy = (next_state != S_IDLE) && (next_state != S_IGNORE);
   end

   ////////////////////////////////////////////////////////////////////////////
   // state registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         clk_sync <= 3'h7;
         dat_sync <= 3'h7;
         clk_f <= 1'h1;
         dat_f <= 1'h1;
         clk_p <= 1'h1;
         dat_p <= 1'h1;
         state <= S_IDLE;
         shift <= 8'h00;
         bit_cnt <= 4'h0;
         dir <= 1'h0;
         first <= 1'h0;
         nack <= 1'h0;
         oe <= 1'h0;
         reg_ptr <= smbus_pkg::PTR_RESET;
         wr_valid <= 1'h0;
         wr_addr <= 8'h00;
         wr_data <= 8'h00;
         busy <= 1'h0;
         low_cnt <= '0;
         high_cnt <= '0;
      end else begin
         clk_sync <= next_clk_sync;
         dat_sync <= next_dat_sync;
         clk_f <= next_clk_f;
         dat_f <= next_dat_f;
         clk_p <= next_clk_p;
         dat_p <= next_dat_p;
         state <= next_state;
         shift <= next_shift;
         bit_cnt <= next_bit_cnt;
         dir <= next_dir;
         first <= next_first;
         nack <= next_nack;
         oe <= next_oe;
         reg_ptr <= next_reg_ptr;
         wr_valid <= next_wr_valid;
         wr_addr <= next_wr_addr;
         wr_data <= next_wr_data;
         busy <= next_busy;
         low_cnt <= next_low_cnt;
         high_cnt <= next_high_cnt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // open-drain data drive: only ever pulls low
   assign bus.dev_data_oe = oe;
   assign bus.dev_data_out = 1'h0;
endmodule : smbus_client
`default_nettype wire

// ### common/smbus_pkg.sv
// Purpose: shared constants for the two-wire client and its host end
// Assumes: system clock of 10 MHz on both ends
// Notes: bus addresses, opcodes and cycle counts live here only
package smbus_pkg;
   // system clock period in ns
   localparam int CLK_PERIOD_NS = 100;
   // fixed seven-bit client address, binary 0101000
   localparam logic [6:0] CLIENT_ADDR = 7'h28;
   // direction indicator values
   localparam logic DIR_WRITE = 1'h0;
   localparam logic DIR_READ = 1'h1;
   // bits per byte
   localparam logic [3:0] BYTE_BITS = 4'h8;
   // register pointer value after reset
   localparam logic [7:0] PTR_RESET = 8'h00;
   // clock-low timeout, in ms, and its cycle count
   localparam int TIMEOUT_MS = 30;
   localparam int TIMEOUT_CYCLES = TIMEOUT_MS * 1000000 / CLK_PERIOD_NS;
   // bus idle time, in us, and its cycle count
   localparam int IDLE_US = 200;
   localparam int IDLE_CYCLES = IDLE_US * 1000 / CLK_PERIOD_NS;
   // bus clock period made by the host, in ns, and a quarter of it in cycles
   localparam int BUS_PERIOD_NS = 10000;
   localparam int QUARTER_CYCLES = BUS_PERIOD_NS / 4 / CLK_PERIOD_NS;
   // host request opcodes
   localparam logic [1:0] OP_START = 2'h0;
   localparam logic [1:0] OP_STOP = 2'h1;
   localparam logic [1:0] OP_WRITE = 2'h2;
   localparam logic [1:0] OP_READ = 2'h3;
endpackage : smbus_pkg

// ### common/smbus_if.sv
// Purpose: open-drain two-wire bus joining host end and client end
// Assumes: both lines have pull-ups; a low driver always wins
// Notes: no end drives a high; an enabled driver with out=0 pulls low
`timescale 1ns/100ps
`default_nettype none
interface smbus_if;
   // host drives of the clock line
   logic host_clk_out;
   logic host_clk_oe;
   // host and client drives of the data line
   logic host_data_out;
   logic host_data_oe;
   logic dev_data_out;
   logic dev_data_oe;
   // resolved wire levels
   logic bus_clock_line;
   logic bus_data_line;
   // wired-and with pull-up
   assign bus_clock_line = !(host_clk_oe && !host_clk_out);
   assign bus_data_line = !((host_data_oe && !host_data_out) || (dev_data_oe && !dev_data_out));
   modport client (input bus_clock_line, input bus_data_line,
                   output dev_data_out, output dev_data_oe);
   modport host (input bus_clock_line, input bus_data_line,
                 output host_clk_out, output host_clk_oe,
                 output host_data_out, output host_data_oe);
endinterface : smbus_if
`default_nettype wire

// ### core/smbus_host.sv
// Purpose: host end of the two-wire bus, one bus operation per request
// Assumes: the client never stretches the clock
// Notes: bus clock is made here by a quarter-period divider
`timescale 1ns/100ps
`default_nettype none
module smbus_host #(
   parameter int QUARTER_CYCLES = smbus_pkg::QUARTER_CYCLES
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // bus side
   smbus_if.host bus,
   // request
   input wire logic req_valid,
   input wire logic [1:0] req_op,
   input wire logic [7:0] req_data,
   input wire logic req_last,
   output logic req_ready,
   // answer
   output logic rsp_valid,
   output logic [7:0] rsp_data,
   output logic rsp_ack
);
   ////////////////////////////////////////////////////////////////////////////
   // declarations
   typedef enum logic [1:0] {H_IDLE, H_START, H_STOP, H_BIT} hstate_type;
   hstate_type state, next_state;   // operation in progress
   logic [2:0] dsync, next_dsync;   // data line synchroniser
   logic dat_f, next_dat_f;         // filtered data level
   logic [7:0] div, next_div;       // quarter-period divider
   logic [1:0] q, next_q;           // quarter within a bit
   logic [3:0] bit_i, next_bit_i;   // bit index, 8 is the ack slot
   logic rd, next_rd;               // operation reads
   logic last, next_last;           // read byte is the final one
   logic [7:0] shift, next_shift;   // byte shifter
   logic clk_oe, next_clk_oe;       // clock pull-down
   logic dat_oe, next_dat_oe;       // data pull-down
   logic next_req_ready, next_rsp_valid, next_rsp_ack;
   logic [7:0] next_rsp_data;
   logic tick;

   ////////////////////////////////////////////////////////////////////////////
   // next-state logic
   always_comb begin
      next_dsync = {dsync[1:0], bus.bus_data_line};
      next_dat_f = (dsync[1] == dsync[2]) ? dsync[2] : dat_f;
      tick = (div == 8'(QUARTER_CYCLES - 1));
      next_div = tick ? 8'h00 : div + 8'h01;
      next_state = state;
      next_q = q;
      next_bit_i = bit_i;
      next_rd = rd;
      next_last = last;
      next_shift = shift;
      next_clk_oe = clk_oe;
      next_dat_oe = dat_oe;
      next_req_ready = req_ready;
      next_rsp_valid = 1'h0;
      next_rsp_data = rsp_data;
      next_rsp_ack = rsp_ack;
      if (state != H_IDLE && tick) begin
         next_q = q + 2'h1;
      end
      case (state)
         H_IDLE: begin
            // take a request
            next_div = 8'h00;
            if (req_valid && req_ready) begin
               next_req_ready = 1'h0;
               next_q = 2'h0;
               next_bit_i = 4'h0;
               next_rd = (req_op == smbus_pkg::OP_READ);
               next_last = req_last;
               next_shift = req_data;
               case (req_op)
                  smbus_pkg::OP_START: next_state = H_START;
                  smbus_pkg::OP_STOP: next_state = H_STOP;
                  default: next_state = H_BIT;
               endcase
            end
         end
         H_START: begin
            // data falls while clock high, then clock low
            if (tick) begin
               case (q)
                  2'h0: next_dat_oe = 1'h0;
                  2'h1: next_clk_oe = 1'h0;
                  2'h2: next_dat_oe = 1'h1;
                  default: begin
                     next_clk_oe = 1'h1;
                     next_state = H_IDLE;
                     next_req_ready = 1'h1;
                  end
               endcase
            end
         end
         H_STOP: begin
            // data rises while clock high
            if (tick) begin
               case (q)
                  2'h0: begin
                     next_dat_oe = 1'h1;
                     next_clk_oe = 1'h1;
                  end
                  2'h1: next_clk_oe = 1'h0;
                  2'h2: next_dat_oe = 1'h0;
                  default: begin
                     next_state = H_IDLE;
                     next_req_ready = 1'h1;
                  end
               endcase
            end
         end
         H_BIT: begin
            // eight data bits msb first, then the ack slot
            if (tick) begin
               case (q)
                  2'h0: begin
                     if (bit_i != 4'h8) begin
                        next_dat_oe = !rd && !shift[7];
                     end else begin
                        next_dat_oe = rd && !last;
                     end
                  end
                  2'h1: next_clk_oe = 1'h0;
                  2'h2: begin
                     if (bit_i != 4'h8) begin
                        next_shift = {shift[6:0], dat_f};
                     end else begin
                        next_rsp_ack = !dat_f;
                     end
                  end
                  default: begin
                     next_clk_oe = 1'h1;
                     if (bit_i == 4'h8) begin
                        next_dat_oe = 1'h0;
                        next_state = H_IDLE;
                        next_req_ready = 1'h1;
                        next_rsp_valid = 1'h1;
                        next_rsp_data = shift;
                     end else begin
                        next_bit_i = bit_i + 4'h1;
                     end
                  end
               endcase
            end
         end
         default: next_state = H_IDLE;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // state registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dsync <= 3'h7;
         dat_f <= 1'h1;
         div <= 8'h00;
         state <= H_IDLE;
         q <= 2'h0;
         bit_i <= 4'h0;
         rd <= 1'h0;
         last <= 1'h0;
         shift <= 8'h00;
         clk_oe <= 1'h0;
         dat_oe <= 1'h0;
         req_ready <= 1'h1;
         rsp_valid <= 1'h0;
         rsp_data <= 8'h00;
         rsp_ack <= 1'h0;
      end else begin
         dsync <= next_dsync;
         dat_f <= next_dat_f;
         div <= next_div;
         state <= next_state;
         q <= next_q;
         bit_i <= next_bit_i;
         rd <= next_rd;
         last <= next_last;
         shift <= next_shift;
         clk_oe <= next_clk_oe;
         dat_oe <= next_dat_oe;
         req_ready <= next_req_ready;
         rsp_valid <= next_rsp_valid;
         rsp_data <= next_rsp_data;
         rsp_ack <= next_rsp_ack;
      end
   end

   // open-drain drives
   assign bus.host_clk_oe = clk_oe;
   assign bus.host_clk_out = 1'h0;
   assign bus.host_data_oe = dat_oe;
   assign bus.host_data_out = 1'h0;
endmodule : smbus_host
`default_nettype wire

// ### bench/smbus_checker.sv
// Purpose: wire-level checks between the host end and the client end
// Assumes: one clock domain; bus levels sampled on each clk edge
// Notes: helper logic tracks bit position, direction and quiet state
`timescale 1ns/100ps
`default_nettype none
module smbus_checker (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // bus signals
   input wire logic host_clk_oe,
   input wire logic dev_data_oe,
   input wire logic bus_clock_line,
   input wire logic bus_data_line
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   logic scl_d, sda_d; // levels one cycle ago
   logic start, stop, rise, hit; // bus events
   logic first, rd, quiet; // address byte, read, client must be silent
   logic [3:0] nbit; // clock rises within the byte
   logic [7:0] sh; // bits seen so far
   assign start = scl_d && bus_clock_line && sda_d && !bus_data_line;
   assign stop = scl_d && bus_clock_line && !sda_d && bus_data_line;
   assign rise = !scl_d && bus_clock_line;
   assign hit = sh[7:1] == smbus_pkg::CLIENT_ADDR;
   ////////////////////////////////////////////////////////////////
   // follow the framing from the wire alone
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         scl_d <= 1'h1;
         sda_d <= 1'h1;
         nbit <= 4'h0;
         sh <= 8'h00;
         first <= 1'h1;
         rd <= 1'h0;
         quiet <= 1'h1;
      end else begin
         scl_d <= bus_clock_line;
         sda_d <= bus_data_line;
         if (start) begin
            nbit <= 4'h0;
            first <= 1'h1;
            quiet <= 1'h0;
         end else if (stop) begin
            quiet <= 1'h1;
         end else if (rise && nbit != 4'h8) begin
            nbit <= nbit + 4'h1;
            sh <= {sh[6:0], bus_data_line};
         end else if (rise) begin
            // ninth rise: acknowledge slot
            nbit <= 4'h0;
            first <= 1'h0;
            if (first) rd <= sh[0];
            if ((first && !hit) || (!first && rd && bus_data_line)) quiet <= 1'h1;
         end
      end
   end
   ////////////////////////////////////////////////////////////////
   a_addr_ack: assert property (rise && nbit == 4'h8 && first && hit |-> dev_data_oe)
      else $error("own address not acknowledged");
   a_foreign_nack: assert property (rise && nbit == 4'h8 && first && !hit |-> !dev_data_oe)
      else $error("foreign address acknowledged");
   a_write_ack: assert property (rise && nbit == 4'h8 && !first && !rd && !quiet |-> dev_data_oe)
      else $error("written byte not acknowledged");
   a_read_no_ack: assert property (rise && nbit == 4'h8 && !first && rd |-> !dev_data_oe)
      else $error("client drove a read acknowledge slot");
   a_quiet_release: assert property (quiet |-> !dev_data_oe)
      else $error("client drove data while it should be silent");
   a_stop_release: assert property (stop |=> !dev_data_oe [*3])
      else $error("client drove data after stop");
   a_steady_high: assert property (bus_clock_line && scl_d |-> dev_data_oe == $past(dev_data_oe))
      else $error("client changed data while clock high");
   a_clock_free: assert property (!host_clk_oe |-> bus_clock_line)
      else $error("clock held low by the client");
   a_start_clock: assert property (start |-> ##[1:40] host_clk_oe)
      else $error("host did not pull clock after start");
endmodule : smbus_checker
`default_nettype wire

// ### bench/smbus_client_interface_tb.sv
// Purpose: host end driving client end across the open-drain bus
// Assumes: register space modelled as reg_ptr xor 5A
// Notes: client counts shortened by parameters
`timescale 1ns/100ps
`default_nettype none
module smbus_client_interface_tb;
   logic clk = 1'h0; // system clock
   logic rst_n, req_valid, req_last, req_ready, rsp_valid, rsp_ack;
   logic timeout_enable, wr_valid, busy;
   logic [1:0] req_op;
   logic [7:0] req_data, rsp_data, rd_data, reg_ptr, wr_addr, wr_data;
   int n_errors, check_count, nwr; // nwr counts write pulses
   smbus_if smbus_if_i ();
   smbus_host smbus_host_i (.clk(clk), .rst_n(rst_n), .bus(smbus_if_i.host),
      .req_valid(req_valid), .req_op(req_op), .req_data(req_data), .req_last(req_last),
      .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_ack(rsp_ack));
   smbus_client #(.TIMEOUT_CYCLES(400), .IDLE_CYCLES(200)) smbus_client_i (.clk(clk),
      .rst_n(rst_n), .bus(smbus_if_i.client), .timeout_enable(timeout_enable),
      .rd_data(rd_data), .reg_ptr(reg_ptr), .wr_valid(wr_valid), .wr_addr(wr_addr),
      .wr_data(wr_data), .busy(busy));
   smbus_checker smbus_checker_i (.clk(clk), .rst_n(rst_n),
      .host_clk_oe(smbus_if_i.host_clk_oe), .dev_data_oe(smbus_if_i.dev_data_oe),
      .bus_clock_line(smbus_if_i.bus_clock_line), .bus_data_line(smbus_if_i.bus_data_line));
   assign rd_data = reg_ptr ^ 8'h5A; // register space model
   always #50 clk = ~clk;
   always @(posedge clk) if (wr_valid === 1'h1) nwr <= nwr + 1;
   ////////////////////////////////////////////////////////////////
   task chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // one host request, offered for one clock, then wait for completion
   task op(input logic [1:0] o, input logic [7:0] d, input logic l);
      int n;
      @(posedge clk);
      req_valid <= 1'h1;
      req_op <= o;
      req_data <= d;
      req_last <= l;
      @(posedge clk);
      req_valid <= 1'h0;
      n = 0;
      do begin
         @(posedge clk);
         #1;
         n++;
      end while (req_ready !== 1'h1 && n < 2000);
      chk({7'h00, req_ready}, 8'h01);
   endtask : op
   task st;
      op(smbus_pkg::OP_START, 8'h00, 1'h0);
   endtask : st
   task sp;
      op(smbus_pkg::OP_STOP, 8'h00, 1'h0);
   endtask : sp
   task wr(input logic [7:0] d, input logic a);
      op(smbus_pkg::OP_WRITE, d, 1'h0);
      chk({7'h00, rsp_valid}, 8'h01);
      chk({7'h00, rsp_ack}, {7'h00, a});
   endtask : wr
   task rd(input logic l, input logic [7:0] e);
      op(smbus_pkg::OP_READ, 8'hFF, l);
      chk({7'h00, rsp_valid}, 8'h01);
      chk(rsp_data, e);
   endtask : rd
   task results;
      $display("errors %0d checks %0d", n_errors, check_count);
      if (n_errors == 0 && check_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : results
   ////////////////////////////////////////////////////////////////
   // watchdog against a hung bus
   initial begin
      repeat (60000) @(posedge clk);
      n_errors++;
      results();
   end
   initial begin
      {rst_n, req_valid, req_last, timeout_enable} = 4'h0;
      req_op = 2'h0;
      req_data = 8'h00;
      {n_errors, check_count, nwr} = 0;
      repeat (20) @(posedge clk);
      rst_n <= 1'h1;
      #1;
      chk(reg_ptr, smbus_pkg::PTR_RESET);
      // block write across the pointer wrap
      st();
      wr(8'h50, 1'h1);
      wr(8'hFE, 1'h1);
      chk(reg_ptr, 8'hFE);
      for (int i = 0; i < 3; i++) begin
         wr(8'(8'h11 * (i + 1)), 1'h1);
         chk(wr_addr, 8'(8'hFE + i));
         chk(wr_data, 8'(8'h11 * (i + 1)));
      end
      chk(8'(nwr), 8'h03);
      sp();
      chk({7'h00, busy}, 8'h00);
      // pointer set, repeated start, block read
      st();
      wr(8'h50, 1'h1);
      wr(8'h40, 1'h1);
      st();
      wr(8'h51, 1'h1);
      for (int i = 0; i < 3; i++) rd(i == 2, 8'(8'h40 + i) ^ 8'h5A);
      sp();
      // foreign address is ignored
      st();
      wr(8'h52, 1'h0);
      wr(8'h77, 1'h0);
      chk(8'(nwr), 8'h03);
      chk({7'h00, busy}, 8'h00);
      sp();
      // read at the kept pointer
      st();
      wr(8'h51, 1'h1);
      rd(1'h1, 8'h43 ^ 8'h5A);
      sp();
      // clock held low past the timeout resets the client
      @(posedge clk);
      timeout_enable <= 1'h1;
      st();
      wr(8'h51, 1'h1);
      repeat (500) @(posedge clk);
      rd(1'h1, 8'hFF);
      sp();
      results();
   end
endmodule : smbus_client_interface_tb
`default_nettype wire
